// File: verilog/dsp_cfg_pkg.sv
// Shared constants, types and helpers for the DSP filter configuration bank.
// Notes on behaviour
// - Four-bit mode code, reset zero, four named modes.
// - Shelf sign bits: clear sums low-pass, set subtracts high-pass.
// - Shelf enables bits 1/0, reset disabled.
// - Separate 16-bit left/right coefficients, reset zero.
// - Spatial cross sign bits 9/8: add or subtract.
// - Spatial bits 7/6 choose bypass or bank coefficients.
// - Spatial right filter sign bit 5 picks low/high-pass.
package dsp_cfg_pkg;

    localparam int DATA_W = 16;
    localparam int AXI_DATA_W = 32;

    // Printed offsets are register indices; the byte address is four times the index.
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_MODE = 8'h40;
    localparam logic [7:0] IDX_SHELF_CFG = 8'h41;
    localparam logic [7:0] IDX_SHELF_LEFT = 8'h42;
    localparam logic [7:0] IDX_SHELF_RIGHT = 8'h43;
    localparam logic [7:0] IDX_SPATIAL_CFG = 8'h44;

    // Writable bits of each register; the rest read as zero.
    localparam logic [15:0] MODE_MASK = 16'h000F;
    localparam logic [15:0] SHELF_CFG_MASK = 16'h0033;
    localparam logic [15:0] COEFF_MASK = 16'hFFFF;
    localparam logic [15:0] SPATIAL_CFG_MASK = 16'h03F3;

    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] SHELF_CFG_RESET = 16'h0000;
    localparam logic [15:0] COEFF_RESET = 16'h0000;
    localparam logic [15:0] SPATIAL_CFG_RESET = 16'h0000;

    // Field positions of the left channel; the right channel sits one bit higher.
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;
    localparam int SHELF_EN_LSB = 0;
    localparam int SHELF_SIGN_LSB = 4;
    localparam int SPATIAL_EN_LSB = 0;
    localparam int SPATIAL_FILT_SIGN_LSB = 4;
    localparam int SPATIAL_BANK_LSB = 6;
    localparam int SPATIAL_CROSS_SIGN_LSB = 8;

    // Full-scale coefficient lets the spatial low-pass track its input, i.e. bypass.
    localparam logic [15:0] BYPASS_COEFF = 16'hFFFF;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        MODE_RECORD = 4'h0,
        MODE_PLAYBACK = 4'h1,
        MODE_GENERAL_1 = 4'h2,
        MODE_GENERAL_2 = 4'h3
    } dsp_mode_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_GOT_ADDR = 2'b01,
        WR_RESP = 2'b11,
        WR_GOT_DATA = 2'b10
    } wr_state_t;

    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } rd_state_t;

    typedef struct packed {
        logic enable;
        logic sign;
        logic [DATA_W-1:0] coeff;
    } section_cfg_t;

    typedef struct packed {
        logic enable;
        logic cross_sign;
        logic bank_select;
        logic filter_sign;
    } spatial_cfg_t;

    function automatic logic [DATA_W-1:0] saturate(input logic signed [DATA_W+1:0] v);
        logic signed [DATA_W+1:0] hi;
        logic signed [DATA_W+1:0] lo;
        hi = (DATA_W + 2)'(2 ** (DATA_W - 1) - 1);
        lo = -hi - (DATA_W + 2)'(1);
        if (v > hi) begin
            return hi[DATA_W-1:0];
        end else if (v < lo) begin
            return lo[DATA_W-1:0];
        end
        return v[DATA_W-1:0];
    endfunction

endpackage

// File: verilog/one_pole_section.sv
// One-pole filter section giving a summed low-pass or subtracted high-pass result.
`timescale 1ns/1ps
module one_pole_section (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic valid_in,
    input wire dsp_cfg_pkg::section_cfg_t cfg_in,
    input wire logic [dsp_cfg_pkg::DATA_W-1:0] sample_in,
    output logic valid_out,
    output logic [dsp_cfg_pkg::DATA_W-1:0] result_out
);
    localparam int W = dsp_cfg_pkg::DATA_W;

    logic signed [W-1:0] state_reg;
    logic signed [W:0] diff;
    logic signed [2*W+1:0] prod;
    logic signed [W:0] state_sum;
    logic signed [W-1:0] state_next;
    logic signed [W:0] high_part;
    logic [W-1:0] result_next;

    // The coefficient is an unsigned fraction of full scale.
    always_comb begin
        diff = {sample_in[W-1], sample_in} - {state_reg[W-1], state_reg};
        prod = diff * $signed({1'b0, cfg_in.coeff});
        state_sum = {state_reg[W-1], state_reg} + prod[2*W:W];
        state_next = state_sum[W-1:0];
        high_part = {sample_in[W-1], sample_in} - {state_next[W-1], state_next};
        if (!cfg_in.enable) begin
            result_next = sample_in;
        end else if (cfg_in.sign) begin
            result_next = dsp_cfg_pkg::saturate({high_part[W], high_part});
        end else begin
            result_next = state_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= '0;
        end else if (valid_in) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            result_out <= '0;
            valid_out <= 1'b0;
        end else begin
            valid_out <= valid_in;
            if (valid_in) begin
                result_out <= result_next;
            end
        end
    end
endmodule

// File: verilog/dsp_filter_config_bank.sv
// Register bank and stereo shelf / spatial enhancement datapath behind AXI4-Lite.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module dsp_filter_config_bank #(
    parameter int ADDR_W = 12
) (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [ADDR_W-1:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [ADDR_W-1:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    input wire logic SAMPLE_VALID_IN,
    input wire logic [15:0] SAMPLE_LEFT_IN,
    input wire logic [15:0] SAMPLE_RIGHT_IN,
    output logic SAMPLE_VALID_OUT,
    output logic [15:0] SAMPLE_LEFT_OUT,
    output logic [15:0] SAMPLE_RIGHT_OUT,
    output logic [3:0] DSP_MODE_OUT
);
    localparam int W = dsp_cfg_pkg::DATA_W;
    localparam int IDX_HI = dsp_cfg_pkg::IDX_LSB + dsp_cfg_pkg::IDX_W;

    dsp_cfg_pkg::wr_state_t wr_state_reg;
    dsp_cfg_pkg::rd_state_t rd_state_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    dsp_cfg_pkg::dsp_mode_t mode_reg;
    logic [15:0] shelf_cfg_reg;
    logic [15:0] shelf_left_reg;
    logic [15:0] shelf_right_reg;
    logic [15:0] spatial_cfg_reg;

    logic wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic [15:0] mode_word;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[IDX_HI-1:dsp_cfg_pkg::IDX_LSB];
        if (addr[ADDR_W-1:IDX_HI] != '0) begin
            return 1'b0;
        end
        return (idx == dsp_cfg_pkg::IDX_MODE) || (idx == dsp_cfg_pkg::IDX_SHELF_CFG) ||
               (idx == dsp_cfg_pkg::IDX_SHELF_LEFT) || (idx == dsp_cfg_pkg::IDX_SHELF_RIGHT) ||
               (idx == dsp_cfg_pkg::IDX_SPATIAL_CFG);
    endfunction

    // Byte lanes above bit 15 hold nothing, so only strobes 0 and 1 matter.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        return v & mask;
    endfunction

    // Address and data are taken in either order; the response follows both.
    always_comb begin
        AWREADY_OUT = (wr_state_reg == dsp_cfg_pkg::WR_IDLE) ||
                      (wr_state_reg == dsp_cfg_pkg::WR_GOT_DATA);
        WREADY_OUT = (wr_state_reg == dsp_cfg_pkg::WR_IDLE) ||
                     (wr_state_reg == dsp_cfg_pkg::WR_GOT_ADDR);
        BVALID_OUT = (wr_state_reg == dsp_cfg_pkg::WR_RESP);
        ARREADY_OUT = (rd_state_reg == dsp_cfg_pkg::RD_IDLE);
        RVALID_OUT = (rd_state_reg == dsp_cfg_pkg::RD_DATA);
        wr_fire = (AWREADY_OUT && AWVALID_IN && (WVALID_IN ||
                   wr_state_reg == dsp_cfg_pkg::WR_GOT_DATA)) ||
                  (wr_state_reg == dsp_cfg_pkg::WR_GOT_ADDR && WVALID_IN);
        wr_addr = (wr_state_reg == dsp_cfg_pkg::WR_GOT_ADDR) ? awaddr_reg : AWADDR_IN;
        wr_data = (wr_state_reg == dsp_cfg_pkg::WR_GOT_DATA) ? wdata_reg : WDATA_IN;
        wr_strb = (wr_state_reg == dsp_cfg_pkg::WR_GOT_DATA) ? wstrb_reg : WSTRB_IN;
        wr_idx = wr_addr[IDX_HI-1:dsp_cfg_pkg::IDX_LSB];
        rd_idx = ARADDR_IN[IDX_HI-1:dsp_cfg_pkg::IDX_LSB];
        mode_word = merge({12'h000, mode_reg}, wr_data, wr_strb, dsp_cfg_pkg::MODE_MASK);
    end

    assign BRESP_OUT = bresp_reg;
    assign RDATA_OUT = rdata_reg;
    assign RRESP_OUT = rresp_reg;

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            wr_state_reg <= dsp_cfg_pkg::WR_IDLE;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bresp_reg <= dsp_cfg_pkg::RESP_OKAY;
        end else begin
            if (wr_fire) begin
                wr_state_reg <= dsp_cfg_pkg::WR_RESP;
                bresp_reg <= is_mapped(wr_addr) ? dsp_cfg_pkg::RESP_OKAY
                                                : dsp_cfg_pkg::RESP_SLVERR;
            end else begin
                case (wr_state_reg)
                    dsp_cfg_pkg::WR_IDLE: begin
                        if (AWVALID_IN) begin
                            awaddr_reg <= AWADDR_IN;
                            wr_state_reg <= dsp_cfg_pkg::WR_GOT_ADDR;
                        end else if (WVALID_IN) begin
                            wdata_reg <= WDATA_IN;
                            wstrb_reg <= WSTRB_IN;
                            wr_state_reg <= dsp_cfg_pkg::WR_GOT_DATA;
                        end
                    end
                    dsp_cfg_pkg::WR_RESP: begin
                        if (BREADY_IN) begin
                            wr_state_reg <= dsp_cfg_pkg::WR_IDLE;
                        end
                    end
                    default: begin
                        wr_state_reg <= wr_state_reg;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            mode_reg <= dsp_cfg_pkg::dsp_mode_t'(dsp_cfg_pkg::MODE_RESET[3:0]);
            shelf_cfg_reg <= dsp_cfg_pkg::SHELF_CFG_RESET;
            shelf_left_reg <= dsp_cfg_pkg::COEFF_RESET;
            shelf_right_reg <= dsp_cfg_pkg::COEFF_RESET;
            spatial_cfg_reg <= dsp_cfg_pkg::SPATIAL_CFG_RESET;
        end else if (wr_fire && is_mapped(wr_addr)) begin
            case (wr_idx)
                dsp_cfg_pkg::IDX_MODE: begin
                    mode_reg <= dsp_cfg_pkg::dsp_mode_t'(mode_word[3:0]);
                end
                dsp_cfg_pkg::IDX_SHELF_CFG: begin
                    shelf_cfg_reg <= merge(shelf_cfg_reg, wr_data, wr_strb,
                                           dsp_cfg_pkg::SHELF_CFG_MASK);
                end
                dsp_cfg_pkg::IDX_SHELF_LEFT: begin
                    shelf_left_reg <= merge(shelf_left_reg, wr_data, wr_strb,
                                            dsp_cfg_pkg::COEFF_MASK);
                end
                dsp_cfg_pkg::IDX_SHELF_RIGHT: begin
                    shelf_right_reg <= merge(shelf_right_reg, wr_data, wr_strb,
                                             dsp_cfg_pkg::COEFF_MASK);
                end
                default: begin
                    spatial_cfg_reg <= merge(spatial_cfg_reg, wr_data, wr_strb,
                                             dsp_cfg_pkg::SPATIAL_CFG_MASK);
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            rd_state_reg <= dsp_cfg_pkg::RD_IDLE;
            rdata_reg <= '0;
            rresp_reg <= dsp_cfg_pkg::RESP_OKAY;
        end else begin
            case (rd_state_reg)
                dsp_cfg_pkg::RD_IDLE: begin
                    if (ARVALID_IN) begin
                        rd_state_reg <= dsp_cfg_pkg::RD_DATA;
                        rresp_reg <= is_mapped(ARADDR_IN) ? dsp_cfg_pkg::RESP_OKAY
                                                          : dsp_cfg_pkg::RESP_SLVERR;
                        rdata_reg <= '0;
                        if (is_mapped(ARADDR_IN)) begin
                            case (rd_idx)
                                dsp_cfg_pkg::IDX_MODE: rdata_reg <= {28'h000_0000, mode_reg};
                                dsp_cfg_pkg::IDX_SHELF_CFG: rdata_reg <= {16'h0000, shelf_cfg_reg};
                                dsp_cfg_pkg::IDX_SHELF_LEFT: begin
                                    rdata_reg <= {16'h0000, shelf_left_reg};
                                end
                                dsp_cfg_pkg::IDX_SHELF_RIGHT: begin
                                    rdata_reg <= {16'h0000, shelf_right_reg};
                                end
                                default: rdata_reg <= {16'h0000, spatial_cfg_reg};
                            endcase
                        end
                    end
                end
                default: begin
                    if (RREADY_IN) begin
                        rd_state_reg <= dsp_cfg_pkg::RD_IDLE;
                    end
                end
            endcase
        end
    end

    assign DSP_MODE_OUT = mode_reg;

    // Datapath: shelf section per channel, then a filtered cross path from the other side.
    logic [W-1:0] sample_in [2];
    logic [W-1:0] shelf_out [2];
    logic [W-1:0] cross_out [2];
    logic [W-1:0] mix_reg [2];
    logic [1:0] shelf_valid;
    logic [1:0] cross_valid;
    logic mix_valid_reg;

    assign sample_in[0] = SAMPLE_LEFT_IN;
    assign sample_in[1] = SAMPLE_RIGHT_IN;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        dsp_cfg_pkg::section_cfg_t shelf_cfg;
        dsp_cfg_pkg::section_cfg_t cross_cfg;
        dsp_cfg_pkg::spatial_cfg_t spatial;
        logic signed [W:0] mix_sum;

        always_comb begin
            shelf_cfg.enable = shelf_cfg_reg[dsp_cfg_pkg::SHELF_EN_LSB + c];
            shelf_cfg.sign = shelf_cfg_reg[dsp_cfg_pkg::SHELF_SIGN_LSB + c];
            shelf_cfg.coeff = (c == 0) ? shelf_left_reg : shelf_right_reg;
            spatial.enable = spatial_cfg_reg[dsp_cfg_pkg::SPATIAL_EN_LSB + c];
            spatial.cross_sign = spatial_cfg_reg[dsp_cfg_pkg::SPATIAL_CROSS_SIGN_LSB + c];
            spatial.bank_select = spatial_cfg_reg[dsp_cfg_pkg::SPATIAL_BANK_LSB + c];
            spatial.filter_sign = spatial_cfg_reg[dsp_cfg_pkg::SPATIAL_FILT_SIGN_LSB + c];
            cross_cfg.enable = 1'b1;
            cross_cfg.sign = spatial.filter_sign;
            cross_cfg.coeff = spatial.bank_select ? shelf_cfg.coeff
                                                  : dsp_cfg_pkg::BYPASS_COEFF;
            // Subtracting the cross path widens stereo; adding narrows it.
            if (spatial.cross_sign) begin
                mix_sum = $signed({shelf_out[c][W-1], shelf_out[c]}) -
                          $signed({cross_out[c][W-1], cross_out[c]});
            end else begin
                mix_sum = $signed({shelf_out[c][W-1], shelf_out[c]}) +
                          $signed({cross_out[c][W-1], cross_out[c]});
            end
        end

        one_pole_section u_shelf (
            .clk_in(CLK_IN),
            .rst_in(SYS_RST_IN),
            .valid_in(SAMPLE_VALID_IN),
            .cfg_in(shelf_cfg),
            .sample_in(sample_in[c]),
            .valid_out(shelf_valid[c]),
            .result_out(shelf_out[c])
        );

        one_pole_section u_cross (
            .clk_in(CLK_IN),
            .rst_in(SYS_RST_IN),
            .valid_in(shelf_valid[c]),
            .cfg_in(cross_cfg),
            .sample_in(shelf_out[1-c]),
            .valid_out(cross_valid[c]),
            .result_out(cross_out[c])
        );

        always_ff @(posedge CLK_IN) begin
            if (SYS_RST_IN) begin
                mix_reg[c] <= '0;
            end else if (cross_valid[c]) begin
                mix_reg[c] <= spatial.enable ?
                    dsp_cfg_pkg::saturate({mix_sum[W], mix_sum}) : shelf_out[c];
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            mix_valid_reg <= 1'b0;
        end else begin
            mix_valid_reg <= cross_valid[0];
        end
    end

    assign SAMPLE_VALID_OUT = mix_valid_reg;
    assign SAMPLE_LEFT_OUT = mix_reg[0];
    assign SAMPLE_RIGHT_OUT = mix_reg[1];
endmodule

// File: sim/dsp_cfg_props.sv
// Concurrent checks on the register bus and sample path of the filter configuration bank.
`timescale 1ns/1ps
module dsp_cfg_props #(
    parameter int ADDR_W = 12
) (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [ADDR_W-1:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    input wire logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    input wire logic WREADY_OUT,
    input wire logic [1:0] BRESP_OUT,
    input wire logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [ADDR_W-1:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    input wire logic ARREADY_OUT,
    input wire logic [31:0] RDATA_OUT,
    input wire logic [1:0] RRESP_OUT,
    input wire logic RVALID_OUT,
    input wire logic RREADY_IN,
    input wire logic SAMPLE_VALID_IN,
    input wire logic SAMPLE_VALID_OUT,
    input wire logic [3:0] DSP_MODE_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic [3:0] wlow_reg;
    assign aw_hs = AWVALID_IN && AWREADY_OUT;
    assign w_hs = WVALID_IN && WREADY_OUT;
    assign ar_hs = ARVALID_IN && ARREADY_OUT;

    // The low data nibble of each write is held one cycle for the mode comparison.
    always_ff @(posedge CLK_IN) begin
        wlow_reg <= WDATA_IN[3:0];
    end

    sequence write_taken;
        aw_hs && w_hs;
    endsequence
    sequence sample_emerges;
        ##3 SAMPLE_VALID_OUT;
    endsequence

    chk_write_answer: assert property (write_taken |=> BVALID_OUT)
        else $error("write response missing");
    chk_b_stands: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
        else $error("write response dropped");
    chk_write_blocked: assert property (BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT)
        else $error("write accepted while response pending");
    chk_read_answer: assert property (ar_hs |=> RVALID_OUT)
        else $error("read data missing");
    chk_r_stands: assert property (RVALID_OUT && !RREADY_IN |=>
        RVALID_OUT && $stable(RDATA_OUT) && $stable(RRESP_OUT))
        else $error("read data dropped");
    chk_read_blocked: assert property (RVALID_OUT |-> !ARREADY_OUT)
        else $error("read accepted while data pending");
    chk_upper_zero: assert property (RVALID_OUT |-> RDATA_OUT[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_unmapped_read: assert property (ar_hs && ARADDR_IN >= 12'h114 |=>
        RRESP_OUT == 2'b10 && RDATA_OUT == 32'h0000_0000)
        else $error("unmapped read not refused");
    chk_mode_follows: assert property (
        aw_hs && w_hs && AWADDR_IN == 12'h100 && WSTRB_IN[0] |=> DSP_MODE_OUT == wlow_reg)
        else $error("mode output not updated");
    chk_mode_steady: assert property ($changed(DSP_MODE_OUT) |-> $past(aw_hs))
        else $error("mode changed without write");
    chk_sample_latency: assert property (SAMPLE_VALID_IN |-> sample_emerges)
        else $error("sample result late");
    chk_no_stray_out: assert property (SAMPLE_VALID_OUT |-> $past(SAMPLE_VALID_IN, 3))
        else $error("stray sample result");
endmodule

bind dsp_filter_config_bank dsp_cfg_props #(.ADDR_W(ADDR_W)) props_i (
    .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .AWADDR_IN(AWADDR_IN), .AWVALID_IN(AWVALID_IN),
    .AWREADY_OUT(AWREADY_OUT), .WDATA_IN(WDATA_IN), .WSTRB_IN(WSTRB_IN), .WVALID_IN(WVALID_IN),
    .WREADY_OUT(WREADY_OUT), .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT),
    .BREADY_IN(BREADY_IN), .ARADDR_IN(ARADDR_IN), .ARVALID_IN(ARVALID_IN),
    .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT), .RRESP_OUT(RRESP_OUT),
    .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .SAMPLE_VALID_IN(SAMPLE_VALID_IN),
    .SAMPLE_VALID_OUT(SAMPLE_VALID_OUT), .DSP_MODE_OUT(DSP_MODE_OUT)
);

// File: sim/tb.sv
// Self-checking testbench for the filter configuration bank.
`timescale 1ns/1ps
module tb;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, s_valid, o_valid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, mode;
    logic [1:0] bresp, rresp;
    logic [15:0] s_left, s_right, o_left, o_right;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] masks [5] = '{16'h000F, 16'h0033, 16'hFFFF, 16'hFFFF, 16'h03F3};
    logic [15:0] cfgs [4] = '{16'h0000, 16'h0003, 16'h0013, 16'h0023};

    dsp_filter_config_bank #(.ADDR_W(12)) uut (
        .CLK_IN(clk), .SYS_RST_IN(rst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
        .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
        .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
        .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
        .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .SAMPLE_VALID_IN(s_valid),
        .SAMPLE_LEFT_IN(s_left), .SAMPLE_RIGHT_IN(s_right), .SAMPLE_VALID_OUT(o_valid),
        .SAMPLE_LEFT_OUT(o_left), .SAMPLE_RIGHT_OUT(o_right), .DSP_MODE_OUT(mode)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic send_sample(input logic [15:0] l, input logic [15:0] rt,
                               output logic [15:0] lo, output logic [15:0] ro);
        int n;
        n = 0;
        @(posedge clk);
        s_left <= l;
        s_right <= rt;
        s_valid <= 1'b1;
        @(posedge clk);
        s_valid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (o_valid !== 1'b1 && n < 10);
        lo = o_left;
        ro = o_right;
        chk("latency", 32'h3, 32'(n));
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] lo, ro, el, er;
        {rst, awvalid, wvalid, bready, arvalid, rready, s_valid} = 7'h7F & 7'h40;
        {awaddr, araddr, wdata, wstrb, s_left, s_right} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chk("mode_out", 32'h0, {28'h0, mode});
        for (int i = 0; i < 5; i++) begin
            axi_read(12'h100 + 12'(4 * i), d, r);
            chk("reset_value", 32'h0, d);
            chk("rresp", 32'h0, {30'h0, r});
            axi_write(12'h100 + 12'(4 * i), 32'hFFFF_FFFF, 4'hF, r);
            chk("bresp", 32'h0, {30'h0, r});
            axi_read(12'h100 + 12'(4 * i), d, r);
            chk("mask_value", {16'h0, masks[i]}, d);
        end
        for (int i = 0; i < 4; i++) begin
            axi_write(12'h100, 32'(i), 4'h1, r);
            chk("mode_out", 32'(i), {28'h0, mode});
            axi_read(12'h100, d, r);
            chk("mode_read", 32'(i), d);
        end
        axi_write(12'h108, 32'h0000_1234, 4'h1, r);
        axi_read(12'h108, d, r);
        chk("left_coeff", 32'h0000_FF34, d);
        axi_write(12'h10C, 32'h0000_5600, 4'h2, r);
        axi_read(12'h10C, d, r);
        chk("right_coeff", 32'h0000_56FF, d);
        axi_write(12'h114, 32'h0000_0001, 4'hF, r);
        chk("bresp_unmapped", 32'h2, {30'h0, r});
        axi_read(12'h114, d, r);
        chk("rresp_unmapped", 32'h2, {30'h0, r});
        chk("rdata_unmapped", 32'h0, d);
        for (int i = 2; i < 5; i++) begin
            axi_write(12'h100 + 12'(4 * i), 32'h0, 4'hF, r);
        end
        // Shelves pass through; a zero bank coefficient gives a zero low-pass cross term.
        axi_write(12'h104, 32'h0, 4'hF, r);
        axi_write(12'h110, 32'h0000_01D3, 4'hF, r);
        send_sample(16'h1000, 16'h0300, lo, ro);
        chk("spatial_left", 32'h0000_0D00, {16'h0, lo});
        chk("spatial_right", 32'h0000_0300, {16'h0, ro});
        // Bypass coefficient: the low-pass state reaches x*65535/65536, rounded down.
        axi_write(12'h110, 32'h0000_0223, 4'hF, r);
        send_sample(16'h1000, 16'h0300, lo, ro);
        chk("spatial_left", 32'h0000_12FF, {16'h0, lo});
        chk("spatial_right", 32'h0000_02FF, {16'h0, ro});
        axi_write(12'h110, 32'h0, 4'hF, r);
        // A zero coefficient keeps the low-pass state at zero, so both responses are exact.
        for (int k = 0; k < 4; k++) begin
            axi_write(12'h104, {16'h0, cfgs[k]}, 4'hF, r);
            el = (!cfgs[k][0] || cfgs[k][4]) ? 16'h1234 : 16'h0000;
            er = (!cfgs[k][1] || cfgs[k][5]) ? 16'hEDCB : 16'h0000;
            send_sample(16'h1234, 16'hEDCB, lo, ro);
            chk("left_out", {16'h0, el}, {16'h0, lo});
            chk("right_out", {16'h0, er}, {16'h0, ro});
        end
        axi_write(12'h104, 32'h0000_0033, 4'hF, r);
        axi_write(12'h10C, 32'h0000_FFFF, 4'hF, r);
        send_sample(16'h4000, 16'h4000, lo, ro);
        chk("left_out", 32'h0000_4000, {16'h0, lo});
        chk("right_out", 32'h0000_0001, {16'h0, ro});
        wrap_up();
    end
endmodule
